// ===== dadc_pkg.sv
package dadc_pkg;
	// Code width and channel count
	localparam int CODE_W = 10;
	localparam int NCHAN = 2;

	// Register byte addresses
	localparam logic [7:0] STATUS_ADDR = 8'h00;
	localparam logic [7:0] SLEEP_WAKE_ADDR = 8'h04;

	// Status register field positions
	localparam int ST_PWR_A_LSB = 0;
	localparam int ST_PWR_B_LSB = 2;
	localparam int ST_TWOS_BIT = 4;
	localparam int ST_DCS_BIT = 5;
	localparam int ST_LOCK_A_BIT = 6;
	localparam int ST_LOCK_B_BIT = 7;
	localparam int ST_SWAP_BIT = 8;
	localparam int WAKE_W = 24;

	// Output codes, offset binary, before format conversion
	localparam logic [9:0] CODE_MAX = 10'h3FF;
	localparam logic [9:0] CODE_MIN = 10'h000;

	// Four-level configuration input encoding
	localparam logic [1:0] MODE_GND = 2'h0;
	localparam logic [1:0] MODE_THIRD = 2'h1;
	localparam logic [1:0] MODE_TWO_THIRDS = 2'h2;
	localparam logic [1:0] MODE_FULL = 2'h3;

	// Timing figures and derived counts
	localparam int CLK_PERIOD_NS = 8;
	localparam int NAP_WAKE_SAMPLES = 100;
	localparam int DCS_LOCK_SAMPLES = 100;
	localparam int MIN_RATE_PERIOD_NS = 1000;
	localparam int CLK_STOP_NS = 2 * MIN_RATE_PERIOD_NS;
	localparam int CLK_STOP_CYC = CLK_STOP_NS / CLK_PERIOD_NS;
	localparam int SLEEP_WAKE_NS = 1000000;
	localparam int SLEEP_WAKE_CYC_DEF = SLEEP_WAKE_NS / CLK_PERIOD_NS;

	// Per-channel power state, Gray along run-nap-recover
	typedef enum logic [1:0] {
		DADC_RUN = 2'b00,
		DADC_NAP = 2'b01,
		DADC_RECOVER = 2'b11,
		DADC_SLEEP = 2'b10
	} dadc_pwr_e;
endpackage

// ===== dadc_output_ctrl.sv
// Design decisions made here: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module dadc_output_ctrl #(
	parameter logic [dadc_pkg::WAKE_W-1:0] SLEEP_WAKE_CYC =
		dadc_pkg::WAKE_W'(dadc_pkg::SLEEP_WAKE_CYC_DEF)
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [1:0] mode_level_i,
	input wire logic bus_swap_select_i,
	input wire logic chan_a_sample_clock_i,
	input wire logic chan_b_sample_clock_i,
	input wire logic chan_a_output_enable_n_i,
	input wire logic chan_b_output_enable_n_i,
	input wire logic chan_a_power_down_request_i,
	input wire logic chan_b_power_down_request_i,
	input wire logic [dadc_pkg::CODE_W-1:0] chan_a_raw_code_i,
	input wire logic [dadc_pkg::CODE_W-1:0] chan_b_raw_code_i,
	input wire logic chan_a_over_range_i,
	input wire logic chan_b_over_range_i,
	input wire logic chan_a_under_range_i,
	input wire logic chan_b_under_range_i,
	output logic [dadc_pkg::CODE_W-1:0] bus_a_code_o,
	output logic [dadc_pkg::CODE_W-1:0] bus_b_code_o,
	output logic bus_a_overflow_flag_o,
	output logic bus_b_overflow_flag_o,
	output logic bus_a_oe_o,
	output logic bus_b_oe_o,
	output logic bus_a_data_valid_o,
	output logic bus_b_data_valid_o
);
	import dadc_pkg::*;

	// Counter widths sized to the recovery, lock and stop counts
	localparam logic [6:0] NAP_WAKE = 7'(NAP_WAKE_SAMPLES);
	localparam logic [6:0] DCS_LOCK = 7'(DCS_LOCK_SAMPLES);
	localparam logic [8:0] STOP_CYC = 9'(CLK_STOP_CYC);

	// Whole block state, registered in one place
	typedef struct packed {
		// Pins sampled once per clock
		logic [1:0] mode;
		logic swap;
		logic [1:0] clk_prev;
		// Power state and recovery count per channel
		dadc_pwr_e [1:0] pwr;
		logic [1:0] wake_by_sample;
		logic [1:0][WAKE_W-1:0] wake_cnt;
		// Stabilizer lock tracking per channel
		logic [1:0][8:0] idle_cnt;
		logic [1:0][6:0] lock_cnt;
		logic [1:0] locked;
		// Converted results and the two output buses
		logic [1:0][CODE_W-1:0] code;
		logic [1:0] flag;
		logic [CODE_W-1:0] bus_a_code;
		logic [CODE_W-1:0] bus_b_code;
		logic bus_a_flag;
		logic bus_b_flag;
		logic bus_a_oe;
		logic bus_b_oe;
		logic bus_a_valid;
		logic bus_b_valid;
		// Register interface: wake count, ack and read data
		logic [WAKE_W-1:0] sleep_wake;
		logic ack;
		logic [31:0] rdata;
	} dadc_state_s;

	// Registered state and its next value
	dadc_state_s st_ff;
	dadc_state_s nxt_st;

	// Per-channel pins as two-bit groups, bit 0 is channel A
	logic [1:0] samp_clk;
	logic [1:0] oe_n;
	logic [1:0] pd_req;
	logic [1:0][CODE_W-1:0] raw;
	logic [1:0] over;
	logic [1:0] under;

	// Gather the per-channel pins into indexable groups
	assign samp_clk = {chan_b_sample_clock_i, chan_a_sample_clock_i};
	assign oe_n = {chan_b_output_enable_n_i, chan_a_output_enable_n_i};
	assign pd_req = {chan_b_power_down_request_i, chan_a_power_down_request_i};
	assign raw = {chan_b_raw_code_i, chan_a_raw_code_i};
	assign over = {chan_b_over_range_i, chan_a_over_range_i};
	assign under = {chan_b_under_range_i, chan_a_under_range_i};

	// Next state of the whole block
	always_comb begin
		logic twos;
		logic dcs_on;
		logic edge_seen;
		logic [CODE_W-1:0] ob;
		logic [1:0] active;
		logic [1:0] ready;
		// Scratch values start from zero on every pass
		twos = 1'b0;
		dcs_on = 1'b0;
		edge_seen = 1'b0;
		ob = '0;
		active = '0;
		ready = '0;
		// Hold all state unless a branch below changes it
		nxt_st = st_ff;

		// Pins sampled once per clock
		nxt_st.mode = mode_level_i;
		nxt_st.swap = bus_swap_select_i;
		nxt_st.clk_prev = samp_clk;

		// Shared setting, same for both channels
		twos = (st_ff.mode == MODE_TWO_THIRDS) || (st_ff.mode == MODE_FULL);
		dcs_on = (st_ff.mode == MODE_THIRD) || (st_ff.mode == MODE_TWO_THIRDS);
		for (int c = 0; c < NCHAN; c++) begin
			// Rising sample edge: pin high now, low one clock ago
			edge_seen = samp_clk[c] && !st_ff.clk_prev[c];

			// Stabilizer relock after a stopped sample clock
			if (edge_seen) begin
				nxt_st.idle_cnt[c] = '0;
				if (st_ff.lock_cnt[c] != '0) begin
					nxt_st.lock_cnt[c] = st_ff.lock_cnt[c] - 7'h01;
				end else begin
					nxt_st.locked[c] = 1'b1;
				end
			end else if (st_ff.idle_cnt[c] != STOP_CYC) begin
				// No edge yet: count the quiet clocks
				nxt_st.idle_cnt[c] = st_ff.idle_cnt[c] + 9'h001;
			end else begin
				// Clock stopped too long: drop lock and reload the count
				nxt_st.locked[c] = 1'b0;
				nxt_st.lock_cnt[c] = DCS_LOCK;
			end

			// Power state from this channel's own pins only
			if (pd_req[c]) begin
				nxt_st.pwr[c] = oe_n[c] ? DADC_SLEEP : DADC_NAP;
			end else begin
				case (st_ff.pwr[c])
					DADC_RUN: begin
						nxt_st.pwr[c] = DADC_RUN;
					end
					DADC_NAP: begin
						// Reference stayed up: count sample edges
						nxt_st.pwr[c] = DADC_RECOVER;
						nxt_st.wake_by_sample[c] = 1'b1;
						nxt_st.wake_cnt[c] = WAKE_W'(NAP_WAKE);
					end
					DADC_SLEEP: begin
						// Reference restarts: count clocks from the register
						nxt_st.pwr[c] = DADC_RECOVER;
						nxt_st.wake_by_sample[c] = 1'b0;
						nxt_st.wake_cnt[c] = st_ff.sleep_wake;
					end
					DADC_RECOVER: begin
						// Back to run one clock after the count empties
						if (st_ff.wake_cnt[c] == '0) begin
							nxt_st.pwr[c] = DADC_RUN;
						end else if (edge_seen || !st_ff.wake_by_sample[c]) begin
							nxt_st.wake_cnt[c] = st_ff.wake_cnt[c] - WAKE_W'(1);
						end
					end
					default: begin
						nxt_st.pwr[c] = DADC_RUN;
					end
				endcase
			end

			// Convert on each rising sample edge while powered
			active[c] = (st_ff.pwr[c] == DADC_RUN) || (st_ff.pwr[c] == DADC_RECOVER);
			if (edge_seen && active[c]) begin
				// Saturate on a range error, over before under
				if (over[c]) begin
					ob = CODE_MAX;
				end else if (under[c]) begin
					ob = CODE_MIN;
				end else begin
					ob = raw[c];
				end
				nxt_st.code[c] = {ob[CODE_W-1] ^ twos, ob[CODE_W-2:0]};
				nxt_st.flag[c] = over[c] || under[c];
			end

			// Valid needs run, and lock while the stabilizer is on
			ready[c] = (st_ff.pwr[c] == DADC_RUN) && (!dcs_on || st_ff.locked[c]);
		end

		// Bus swap, one clock of fixed latency on both buses
		if (st_ff.swap) begin
			// Straight through: channel A on bus A
			nxt_st.bus_a_code = st_ff.code[0];
			nxt_st.bus_b_code = st_ff.code[1];
			nxt_st.bus_a_flag = st_ff.flag[0];
			nxt_st.bus_b_flag = st_ff.flag[1];
			nxt_st.bus_a_valid = ready[0];
			nxt_st.bus_b_valid = ready[1];
		end else begin
			// Exchanged: channel A on bus B
			nxt_st.bus_a_code = st_ff.code[1];
			nxt_st.bus_b_code = st_ff.code[0];
			nxt_st.bus_a_flag = st_ff.flag[1];
			nxt_st.bus_b_flag = st_ff.flag[0];
			nxt_st.bus_a_valid = ready[1];
			nxt_st.bus_b_valid = ready[0];
		end

		// Each bus drives only with its enable low and its channel awake
		// Sleep and nap release the bus whatever the enable pin says
		nxt_st.bus_a_oe = !oe_n[0] && !pd_req[0] && active[0];
		nxt_st.bus_b_oe = !oe_n[1] && !pd_req[1] && active[1];

		// Wishbone slave, one wait state, ack dropped after one cycle
		nxt_st.ack = wb_cyc_i && wb_stb_i && !st_ff.ack;
		nxt_st.rdata = '0;
		// A write lands at the edge that samples ack, while the master still holds it
		if (wb_cyc_i && wb_stb_i && wb_we_i && st_ff.ack) begin
			if (wb_adr_i == SLEEP_WAKE_ADDR) begin
				// Only the three low byte lanes hold the wake count
				for (int b = 0; b < 3; b++) begin
					if (wb_sel_i[b]) begin
						nxt_st.sleep_wake[b*8 +: 8] = wb_dat_i[b*8 +: 8];
					end
				end
			end
		end
		// Read data is captured with ack so both stand in the same cycle
		if (wb_cyc_i && wb_stb_i && !wb_we_i && !st_ff.ack) begin
			if (wb_adr_i == STATUS_ADDR) begin
				nxt_st.rdata[ST_PWR_A_LSB +: 2] = st_ff.pwr[0];
				nxt_st.rdata[ST_PWR_B_LSB +: 2] = st_ff.pwr[1];
				nxt_st.rdata[ST_TWOS_BIT] = twos;
				nxt_st.rdata[ST_DCS_BIT] = dcs_on;
				nxt_st.rdata[ST_LOCK_A_BIT] = st_ff.locked[0];
				nxt_st.rdata[ST_LOCK_B_BIT] = st_ff.locked[1];
				nxt_st.rdata[ST_SWAP_BIT] = st_ff.swap;
			end else if (wb_adr_i == SLEEP_WAKE_ADDR) begin
				nxt_st.rdata = {{(32-WAKE_W){1'b0}}, st_ff.sleep_wake};
			end
		end
	end

	// State register
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			// Run state, unlocked, full lock count, wake count from the parameter
			st_ff <= '0;
			st_ff.sleep_wake <= SLEEP_WAKE_CYC;
			st_ff.lock_cnt <= {DCS_LOCK, DCS_LOCK};
		end else begin
			// One update per clock for the whole block
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from the state
	assign wb_dat_o = st_ff.rdata;
	assign wb_ack_o = st_ff.ack;

	// Data buses, flags, enables and valid flags
	assign bus_a_code_o = st_ff.bus_a_code;
	assign bus_b_code_o = st_ff.bus_b_code;
	assign bus_a_overflow_flag_o = st_ff.bus_a_flag;
	assign bus_b_overflow_flag_o = st_ff.bus_b_flag;
	assign bus_a_oe_o = st_ff.bus_a_oe;
	assign bus_b_oe_o = st_ff.bus_b_oe;
	assign bus_a_data_valid_o = st_ff.bus_a_valid;
	assign bus_b_data_valid_o = st_ff.bus_b_valid;
endmodule
`default_nettype wire

// ===== dadc_properties.sv
`timescale 1ns/10ps
`default_nettype none
module dadc_properties (
	input wire logic clk_i, sys_rst_i, wb_cyc_i, wb_stb_i, wb_ack_o, bus_swap_select_i,
	input wire logic [1:0] mode_level_i,
	input wire logic chan_a_sample_clock_i, chan_b_sample_clock_i,
	input wire logic chan_a_output_enable_n_i, chan_a_power_down_request_i,
	input wire logic chan_b_power_down_request_i,
	input wire logic [dadc_pkg::CODE_W-1:0] chan_a_raw_code_i, bus_a_code_o, bus_b_code_o,
	input wire logic chan_a_over_range_i, chan_a_under_range_i,
	input wire logic chan_b_over_range_i, chan_b_under_range_i,
	input wire logic bus_a_overflow_flag_o, bus_b_overflow_flag_o,
	input wire logic bus_a_oe_o, bus_b_oe_o, bus_a_data_valid_o, bus_b_data_valid_o
);
	import dadc_pkg::*;
	// Upper level bit picks two's complement
	wire logic twos_sel = mode_level_i[1];
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// Sample clock rising edges
	sequence s_rise_a;
		!chan_a_sample_clock_i ##1 chan_a_sample_clock_i;
	endsequence
	sequence s_rise_b;
		!chan_b_sample_clock_i ##1 chan_b_sample_clock_i;
	endsequence
	AST_OE_A: assert property (chan_a_output_enable_n_i |=> !bus_a_oe_o)
		else $error("bus A driven while disabled");
	AST_PD_B: assert property (chan_b_power_down_request_i |=> !bus_b_oe_o)
		else $error("bus B driven while powered down");
	AST_CODE_A: assert property (s_rise_a ##0 (bus_swap_select_i && bus_a_data_valid_o
		&& !chan_a_over_range_i && !chan_a_under_range_i) |-> ##2
		bus_a_code_o == ($past(chan_a_raw_code_i, 2) ^ {$past(twos_sel, 2), 9'h000}))
		else $error("bus A code wrong");
	AST_OVR_X: assert property (s_rise_b ##0 (!bus_swap_select_i && bus_a_data_valid_o
		&& chan_b_over_range_i) |-> ##2
		bus_a_overflow_flag_o && bus_a_code_o == {~$past(twos_sel, 2), 9'h1FF})
		else $error("bus A lacks saturated channel B");
	AST_UND_B: assert property (s_rise_b ##0 (bus_swap_select_i && bus_b_data_valid_o
		&& chan_b_under_range_i && !chan_b_over_range_i) |-> ##2
		bus_b_overflow_flag_o && bus_b_code_o == {$past(twos_sel, 2), 9'h000})
		else $error("bus B underrange code wrong");
	AST_NAP_A: assert property ($fell(chan_a_power_down_request_i)
		&& !chan_a_output_enable_n_i && bus_swap_select_i |-> !bus_a_data_valid_o [*8])
		else $error("channel A valid too soon");
	AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("access not acknowledged");
	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("acknowledge too long");
endmodule
`default_nettype wire

// ===== dadc_rx_latch.sv
`timescale 1ns/10ps
`default_nettype none
module dadc_rx_latch (
	input wire logic clk_i,
	input wire logic bus_oe_i,
	input wire logic [dadc_pkg::CODE_W-1:0] bus_code_i,
	output logic [dadc_pkg::CODE_W-1:0] held_code_o
);
	import dadc_pkg::*;
	// Latch a driven bus; a released bus reads as a changing pattern
	always_ff @(posedge clk_i) begin
		held_code_o <= bus_oe_i ? bus_code_i : ~held_code_o;
	end
endmodule
`default_nettype wire

// ===== dadc_output_ctrl_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
	$display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end
module dadc_output_ctrl_bench;
	import dadc_pkg::*;
	// Row: mode, swap, raw code, over, under, expected code of channel A
	typedef struct packed {logic [1:0] mode; logic swap; logic [9:0] raw;
		logic ovr; logic und; logic [9:0] exp_a;} dadc_row_s;
	localparam dadc_row_s ROWS [8] = '{'{2'h0, 1'b1, 10'h200, 1'b0, 1'b0, 10'h200},
		'{2'h1, 1'b0, 10'h3FF, 1'b0, 1'b0, 10'h3FF}, '{2'h2, 1'b1, 10'h200, 1'b0, 1'b0, 10'h000},
		'{2'h3, 1'b1, 10'h1FF, 1'b0, 1'b0, 10'h3FF}, '{2'h0, 1'b1, 10'h123, 1'b1, 1'b0, 10'h3FF},
		'{2'h3, 1'b1, 10'h155, 1'b0, 1'b1, 10'h200}, '{2'h2, 1'b0, 10'h000, 1'b0, 1'b0, 10'h200},
		'{2'h0, 1'b0, 10'h001, 1'b1, 1'b1, 10'h3FF}};
	logic clk_i = 1'b0, sys_rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic bus_swap_select_i = 1'b1, chan_a_output_enable_n_i = 1'b0;
	logic chan_b_output_enable_n_i = 1'b0, chan_a_power_down_request_i = 1'b0;
	logic chan_b_power_down_request_i = 1'b0, chan_a_over_range_i = 1'b0;
	logic chan_a_under_range_i = 1'b0, chan_b_over_range_i = 1'b0, chan_b_under_range_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
	logic [1:0] mode_level_i = 2'h0, scnt = 2'h0;
	logic [CODE_W-1:0] chan_a_raw_code_i = 10'h000, chan_b_raw_code_i = 10'h000;
	logic [CODE_W-1:0] bus_a_code_o, bus_b_code_o, held_a, held_b, exp_b;
	logic wb_ack_o, bus_a_overflow_flag_o, bus_b_overflow_flag_o, bus_a_oe_o, bus_b_oe_o;
	logic bus_a_data_valid_o, bus_b_data_valid_o;
	int fail_count = 0, cmp_count = 0, cyc = 0, n;
	logic samp_stop = 1'b0;
	// One sample clock, a quarter of the system rate, feeds both channels
	wire logic chan_a_sample_clock_i = scnt[1] & !samp_stop;
	wire logic chan_b_sample_clock_i = scnt[1] & !samp_stop;
	dadc_output_ctrl #(.SLEEP_WAKE_CYC(24'd20)) u_dadc_output_ctrl (.*);
	dadc_rx_latch u_dadc_rx_latch_a (.clk_i(clk_i), .bus_oe_i(bus_a_oe_o), .bus_code_i(bus_a_code_o),
		.held_code_o(held_a));
	dadc_rx_latch u_dadc_rx_latch_b (.clk_i(clk_i), .bus_oe_i(bus_b_oe_o), .bus_code_i(bus_b_code_o),
		.held_code_o(held_b));
	initial begin
		forever #4 clk_i = ~clk_i;
	end
	// Sample clock divider and hang ceiling
	always @(posedge clk_i) begin
		scnt <= scnt + 2'h1;
		cyc <= cyc + 1;
		if (cyc == 12000) begin
			fail_count++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Classic bus cycle, held until acknowledged
	task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d);
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, we, a, s, d};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
	endtask
	// Count cycles until a valid flag rises
	task automatic wait_valid(input int sel);
		n = 0;
		do begin @(negedge clk_i); n++; end while ((sel ? bus_b_data_valid_o : bus_a_data_valid_o) !== 1'b1);
	endtask
	initial begin
		repeat (12) @(posedge clk_i);
		`CHK({wb_ack_o, bus_a_oe_o, bus_b_oe_o, bus_a_data_valid_o}, 4'h0)
		sys_rst_i <= 1'b0;
		wb(1'b0, SLEEP_WAKE_ADDR, 4'hF, 32'h0);
		`CHK(rd, 32'h14)
		wb(1'b1, SLEEP_WAKE_ADDR, 4'h1, 32'hFFFF_FF0C);
		wb(1'b0, SLEEP_WAKE_ADDR, 4'hF, 32'h0);
		`CHK(rd, 32'h0C)
		wb(1'b0, 8'h10, 4'hF, 32'h0);
		`CHK(rd, 32'h0)
		// Rows change inputs as the sample clock falls
		for (int i = 0; i < 8; i++) begin
			do @(negedge clk_i); while (scnt != 2'h3);
			@(posedge clk_i);
			{mode_level_i, bus_swap_select_i, chan_a_raw_code_i, chan_a_over_range_i,
				chan_a_under_range_i} <= ROWS[i][24:10];
			chan_b_raw_code_i <= ROWS[i].raw ^ 10'h0FF;
			{chan_b_over_range_i, chan_b_under_range_i} <= ROWS[i][11:10];
			exp_b = (ROWS[i].ovr ? 10'h3FF : ROWS[i].und ? 10'h000 : ROWS[i].raw ^ 10'h0FF)
				^ {ROWS[i].mode[1], 9'h000};
			repeat (8) @(negedge clk_i);
			`CHK(ROWS[i].swap ? held_a : held_b, ROWS[i].exp_a)
			`CHK(ROWS[i].swap ? held_b : held_a, exp_b)
			`CHK({bus_a_overflow_flag_o, bus_b_overflow_flag_o}, {2{ROWS[i][11] | ROWS[i][10]}})
			wb(1'b0, STATUS_ADDR, 4'hF, 32'h0);
			`CHK(rd & 32'h13F, {23'h0, ROWS[i].swap, 2'h0, ^ROWS[i].mode, ROWS[i].mode[1], 4'h0})
		end
		// Nap on A only, then recovery
		@(posedge clk_i);
		{bus_swap_select_i, chan_a_power_down_request_i} <= 2'h3;
		repeat (3) @(negedge clk_i);
		`CHK({bus_a_oe_o, bus_b_oe_o}, 2'b01)
		wb(1'b0, STATUS_ADDR, 4'hF, 32'h0);
		`CHK(rd[3:0], 4'h1)
		@(posedge clk_i);
		chan_a_power_down_request_i <= 1'b0;
		wait_valid(0);
		`CHK(n >= 4 * NAP_WAKE_SAMPLES - 4 && n <= 4 * NAP_WAKE_SAMPLES + 8, 1'b1)
		// Sleep on B with the shortened wake count
		@(posedge clk_i);
		{chan_b_output_enable_n_i, chan_b_power_down_request_i} <= 2'h3;
		repeat (3) @(negedge clk_i);
		`CHK({bus_a_oe_o, bus_b_oe_o}, 2'b10)
		wb(1'b0, STATUS_ADDR, 4'hF, 32'h0);
		`CHK(rd[3:0], 4'h8)
		@(posedge clk_i);
		{chan_b_output_enable_n_i, chan_b_power_down_request_i} <= 2'h0;
		wait_valid(1);
		`CHK(n >= 12 && n <= 16, 1'b1)
		// Idle disable of bus A only
		@(posedge clk_i);
		chan_a_output_enable_n_i <= 1'b1;
		repeat (3) @(negedge clk_i);
		`CHK({bus_a_oe_o, bus_b_oe_o, bus_a_data_valid_o}, 3'b011)
		// Quiet sample clock drops both locks; a running one relocks them
		wb(1'b0, STATUS_ADDR, 4'hF, 32'h0);
		`CHK(rd[7:6], 2'h3)
		samp_stop <= 1'b1;
		repeat (CLK_STOP_CYC + 8) @(posedge clk_i);
		wb(1'b0, STATUS_ADDR, 4'hF, 32'h0);
		`CHK(rd[7:6], 2'h0)
		samp_stop <= 1'b0;
		repeat (4 * DCS_LOCK_SAMPLES + 20) @(posedge clk_i);
		wb(1'b0, STATUS_ADDR, 4'hF, 32'h0);
		`CHK(rd[7:6], 2'h3)
		stop_test();
	end
endmodule
bind dadc_output_ctrl dadc_properties u_dadc_properties (.*);
`default_nettype wire
